// ### gain_config_latch.sv
/*
  configuration latch of a serially loaded led sink driver.
  assumes serial clock, data and strobe arrive asynchronously to clk;
  special mode is decided by surrounding mode logic.
*/
`timescale 1ns/100ps
module gain_config_latch
  import gain_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic shift_clock_pin,
  input wire logic serial_data_in,
  input wire logic latch_strobe_pin,
  input wire logic special_mode,
  output logic serial_data_out,
  output logic current_range_multiplier,
  output logic gain_exponent_bit,
  output logic [mant_width-1:0] gain_mantissa,
  output logic [volt_gain_width-1:0] voltage_gain_factor,
  output logic [cur_gain_width-1:0] total_current_gain,
  output logic [3:0] current_ratio
);
  // ==========================================
  // positions of the pins in the synchroniser vector
  localparam int sync_pins = 4;
  localparam int sck_idx = 0;
  localparam int data_idx = 1;
  localparam int strobe_idx = 2;
  localparam int mode_idx = 3;

  // ==========================================
  // synchronisers, two flops per pin
  logic [sync_pins-1:0] pin_raw;
  logic [sync_pins-1:0] pin_meta;
  logic [sync_pins-1:0] pin_sync;
  assign pin_raw = {special_mode, latch_strobe_pin, serial_data_in, shift_clock_pin};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta <= '0;
    end else begin
      pin_meta <= pin_raw;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_sync <= '0;
    end else begin
      pin_sync <= pin_meta;
    end
  end

  logic data_bit;
  logic mode_level;
  assign data_bit = pin_sync[data_idx];
  assign mode_level = pin_sync[mode_idx];

  // ==========================================
  // edge detection, history resets to the idle low level
  logic sck_last;
  logic strobe_last;
  logic sck_rise;
  logic strobe_rise;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_last <= 1'b0;
    end else begin
      sck_last <= pin_sync[sck_idx];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strobe_last <= 1'b0;
    end else begin
      strobe_last <= pin_sync[strobe_idx];
    end
  end

  assign sck_rise = pin_sync[sck_idx] & ~sck_last;
  assign strobe_rise = pin_sync[strobe_idx] & ~strobe_last;

  // ==========================================
  // shift register, first bit ends at the top
  logic [cfg_width-1:0] shreg;
  logic [cfg_width-1:0] next_shreg;

  always_comb begin
    next_shreg = shreg;
    if (sck_rise) begin
      next_shreg = {shreg[cfg_width-2:0], data_bit};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shreg <= '0;
    end else begin
      shreg <= next_shreg;
    end
  end

  // ==========================================
  // serial output, bit pushed out of the top
  logic next_serial_data_out;

  always_comb begin
    next_serial_data_out = serial_data_out;
    if (sck_rise) begin
      next_serial_data_out = shreg[cfg_width-1];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      serial_data_out <= 1'b0;
    end else begin
      serial_data_out <= next_serial_data_out;
    end
  end

  // ==========================================
  // configuration latch, upper byte dropped
  logic [mant_hi:0] cfg;
  logic [mant_hi:0] next_cfg;
  logic cfg_write;
  assign cfg_write = strobe_rise & mode_level;

  always_comb begin
    next_cfg = cfg;
    if (cfg_write) begin
      next_cfg = shreg[mant_hi:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg <= cfg_reset;
    end else begin
      cfg <= next_cfg;
    end
  end

  // ==========================================
  // publish strobe, one cycle after the latch write
  logic publish;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      publish <= 1'b0;
    end else begin
      publish <= cfg_write;
    end
  end

  // ==========================================
  // field extraction and decode
  logic cfg_mult;
  logic cfg_expo;
  logic [mant_width-1:0] mant_rev;
  assign cfg_mult = cfg[mult_bit];
  assign cfg_expo = cfg[exp_bit];

  always_comb begin
    mant_rev = '0;
    for (int i = 0; i < mant_width; i++) begin
      mant_rev[i] = cfg[mant_hi - i];
    end
  end

  logic [volt_gain_width-1:0] volt_gain_c;
  logic [cur_gain_width-1:0] cur_gain_c;
  logic [3:0] ratio_c;

  gain_decode gain_decode_i (
    .mult(cfg_mult),
    .expo(cfg_expo),
    .mant(mant_rev),
    .volt_gain_x256(volt_gain_c),
    .cur_gain_x768(cur_gain_c),
    .ratio(ratio_c)
  );

  // ==========================================
  // registered outputs, moved only by a latch update
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      current_range_multiplier <= cfg_reset[mult_bit];
    end else if (publish) begin
      current_range_multiplier <= cfg_mult;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gain_exponent_bit <= cfg_reset[exp_bit];
    end else if (publish) begin
      gain_exponent_bit <= cfg_expo;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gain_mantissa <= mant_reset;
    end else if (publish) begin
      gain_mantissa <= mant_rev;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      voltage_gain_factor <= volt_gain_reset;
    end else if (publish) begin
      voltage_gain_factor <= volt_gain_c;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      total_current_gain <= cur_gain_reset;
    end else if (publish) begin
      total_current_gain <= cur_gain_c;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      current_ratio <= ratio_high;
    end else if (publish) begin
      current_ratio <= ratio_c;
    end
  end
endmodule

// ### gain_cfg_pkg.sv
/*
  constants for the led current gain configuration latch.
  assumes a 16-bit serial shift register fed msb-first by the host link.
*/
// Overview of operation
// - latch bit 0 selects the current ratio: one gives fifteen, zero gives five.
// - latch bit 1 is the exponent, bits 2 to 7 the mantissa, bits 8 to 15 are ignored.
// - the mantissa is unsigned with bit 2 weighing thirty-two and bit 7 weighing one.
// - voltage gain is (1 + exponent) * (1 + mantissa/64) / 4, giving 128 settings.
// - exponent zero spans 1/4 to 127/256, exponent one spans 1/2 to 127/128, 64 steps each.
// - total gain is voltage gain times three to the power multiplier minus one, 1/12 to 127/128.
// - after power-up multiplier, exponent and mantissa bits are all one, gain about 0.992.
// - a latch strobe in special mode copies the shift register into the configuration latch.
// - the latch holds its value until power-off or a new special-mode strobe.
package gain_cfg_pkg;
  // ==========================================
  // latch layout
  localparam int cfg_width = 16;
  localparam int mult_bit = 0;
  localparam int exp_bit = 1;
  localparam int mant_lo = 2;
  localparam int mant_hi = 7;
  localparam int mant_width = 6;
  localparam logic [mant_width-1:0] mant_reset = 6'h3f;
  localparam logic [7:0] cfg_reset = 8'hff;
  // ==========================================
  // gain arithmetic, voltage gain in 1/256 units, current gain in 1/768 units
  localparam int volt_gain_width = 9;
  localparam int cur_gain_width = 10;
  localparam int gain_frac_bits = 8;
  localparam logic [cur_gain_width-1:0] mant_base = 10'h040;
  localparam logic [volt_gain_width-1:0] volt_gain_reset = 9'h0fe;
  localparam logic [cur_gain_width-1:0] cur_gain_reset = 10'h2fa;
  // ==========================================
  // current ratios
  localparam logic [3:0] ratio_high = 4'hf;
  localparam logic [3:0] ratio_low = 4'h5;
endpackage

// ### gain_decode.sv
/*
  combinational gain decoder.
  assumes a stable 8-bit configuration code from the latch.
*/
`timescale 1ns/100ps
module gain_decode
  import gain_cfg_pkg::*;
(
  input wire logic mult,
  input wire logic expo,
  input wire logic [mant_width-1:0] mant,
  output logic [volt_gain_width-1:0] volt_gain_x256,
  output logic [cur_gain_width-1:0] cur_gain_x768,
  output logic [3:0] ratio
);
  // ==========================================
  // voltage gain: (1+exponent)(64+mantissa)/256
  logic [cur_gain_width-1:0] base;
  always_comb begin
    base = mant_base + {4'h0, mant};
    volt_gain_x256 = expo ? base[volt_gain_width-1:0] << 1 : base[volt_gain_width-1:0];
    // total gain in 1/768 units: multiplier one times 3, zero times 1
    cur_gain_x768 = mult ? cur_gain_width'(3 * volt_gain_x256) : {1'b0, volt_gain_x256};
    ratio = mult ? ratio_high : ratio_low;
  end
endmodule

// ### gain_cfg_checker_assertions.sv
/* gain latch output checks. assumes the bind below. */
`timescale 1ns/100ps
module gain_cfg_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic latch_strobe_pin,
  input wire logic current_range_multiplier,
  input wire logic [8:0] voltage_gain_factor,
  input wire logic [9:0] total_current_gain
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire m = current_range_multiplier;
  wire [8:0] v = voltage_gain_factor;
  wire [9:0] c = total_current_gain;
  sequence quiet; $stable(latch_strobe_pin)[*8]; endsequence
  a_gain_triple: assert property (m |-> c == 10'h003 * v) else $error("gain high");
  a_gain_plain: assert property (!m |-> c == {1'h0, v}) else $error("gain low");
  a_volt_band: assert property (v inside {[9'h040:9'h0fe]}) else $error("volt band");
  a_volt_step: assert property (!v[0] || v < 9'h080) else $error("step");
  a_gain_band: assert property (c inside {[10'h040:10'h2fa]}) else $error("gain band");
  a_reset_ones: assert property ($rose(nrst) |-> m && v == 9'h0fe && c == 10'h2fa) else $error("reset");
  a_hold_quiet: assert property (quiet |=> $stable(c)) else $error("hold");
  a_strobe_lag: assert property ($rose(latch_strobe_pin) |=> $stable(c)[*2]) else $error("lag");
endmodule
bind gain_config_latch gain_cfg_checker gain_cfg_checker_i (.clk, .nrst, .latch_strobe_pin,
  .current_range_multiplier, .voltage_gain_factor, .total_current_gain);

// ### host_link.sv
/* host link model. assumes clk paces it. */
`timescale 1ns/100ps
module host_link (
  input wire logic clk,
  output logic shift_clock_pin,
  output logic serial_data_in,
  output logic latch_strobe_pin
);
  initial {shift_clock_pin, serial_data_in, latch_strobe_pin} = 3'h0;
  task automatic send(input logic [15:0] code);
    for (int i = 0; i < 128; i++)
      @(negedge clk) {serial_data_in, shift_clock_pin} = {code[15 - i / 8], i[2]};
    @(negedge clk) {serial_data_in, shift_clock_pin, latch_strobe_pin} = {~serial_data_in, 2'h1};
    repeat (4) @(negedge clk);
    latch_strobe_pin = 1'h0;
  endtask
endmodule

// ### led_current_gain_config_latch_tb.sv
/* gain latch bench. assumes host_link on the pins. */
`timescale 1ns/100ps
module led_current_gain_config_latch_tb;
  logic clk = 0, nrst = 0, special_mode = 0;
  wire shift_clock_pin, serial_data_in, latch_strobe_pin;
  logic [8:0] voltage_gain_factor;
  logic [9:0] total_current_gain, v;
  logic [3:0] current_ratio;
  logic [16:0] code [5] = '{17'h1ff00, 17'h112fe, 17'h03456, 17'h1ab81, 17'h1ffff};
  logic [7:0] cur = 8'hff;
  logic serial_data_out, current_range_multiplier, gain_exponent_bit;
  logic [5:0] gain_mantissa;
  logic [15:0] last = 16'h0000;
  int num_errors = 0, num_checks = 0;
  always #4 clk = ~clk;
  gain_config_latch gain_config_latch_i (.clk, .nrst, .shift_clock_pin, .serial_data_in, .latch_strobe_pin,
    .special_mode, .serial_data_out, .current_range_multiplier, .gain_exponent_bit, .gain_mantissa,
    .voltage_gain_factor, .total_current_gain, .current_ratio);
  host_link host_link_i (.clk, .shift_clock_pin, .serial_data_in, .latch_strobe_pin);
  task automatic check(input string name, input logic [9:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic test_done();
    $display("%0d checks %0d errors", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic expect_cur();
    v = (10'h001 + cur[1]) * (10'h040 + {cur[2], cur[3], cur[4], cur[5], cur[6], cur[7]});
    check("volt gain", v, {1'h0, voltage_gain_factor});
    check("current gain", cur[0] ? 10'h003 * v : v, total_current_gain);
    check("ratio", cur[0] ? 10'h00f : 10'h005, {6'h00, current_ratio});
    check("multiplier", {9'h000, cur[0]}, {9'h000, current_range_multiplier});
    check("exponent", {9'h000, cur[1]}, {9'h000, gain_exponent_bit});
    check("mantissa", {4'h0, cur[2], cur[3], cur[4], cur[5], cur[6], cur[7]}, {4'h0, gain_mantissa});
  endtask
  initial begin
    repeat (6) @(negedge clk);
    nrst = 1;
    expect_cur();
    foreach (code[i]) begin
      special_mode = code[i][16];
      host_link_i.send(code[i][15:0]);
      repeat (4) @(negedge clk);
      if (code[i][16]) cur = code[i][7:0];
      expect_cur();
      check("serial out", {9'h000, last[0]}, {9'h000, serial_data_out});
      last = code[i][15:0];
    end
    test_done();
  end
endmodule
